/* File: hw/cmps_pkg.sv */
// Constants shared by the switching-cycle controller and its testbench
package cmps_pkg;

  // ==========================================================================
  // Clock
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1_000;
  localparam int unsigned CYC_PER_US_X  = CLK_HZ / 1_000_000;

  // ==========================================================================
  // Oscillator
  localparam int unsigned FSW_HZ        = 65_000;
  localparam int unsigned PER_NOM       = CLK_HZ / FSW_HZ;
  localparam int unsigned JIT_PCT       = 4;
  localparam int unsigned JIT_DEV       = PER_NOM * JIT_PCT / 100;
  localparam int unsigned JIT_PERIOD_MS = 4;
  localparam int unsigned DMAX_NUM      = 3;
  localparam int unsigned DMAX_DEN      = 4;
  localparam int unsigned PER_W         = 10;
  localparam int unsigned OFS_W         = 6;

  // ==========================================================================
  // Gate timing, least times round up
  localparam int unsigned MINOFF_NS     = 156;
  localparam int unsigned MINOFF_CYC    = (MINOFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEB_NS        = 220;
  localparam int unsigned LEB_CYC       = (LEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DLY_W         = 3;

  // ==========================================================================
  // Soft start
  localparam int unsigned SS_STEPS      = 32;
  localparam int unsigned SS_STEP_W     = 5;
  localparam int unsigned SS_STEP_US    = 600;
  localparam int unsigned SS_TOTAL_MS   = 20;
  localparam int unsigned TMR_W         = 20;

  // ==========================================================================
  // Synchroniser lanes
  localparam int unsigned SYNC_W        = 5;
  localparam int unsigned LN_FB         = 0;
  localparam int unsigned LN_SS         = 1;
  localparam int unsigned LN_CL         = 2;
  localparam int unsigned LN_BCL        = 3;
  localparam int unsigned LN_UVLO       = 4;

endpackage

/* File: hw/cmps_sync.sv */
// Two-stage synchroniser for asynchronous comparator and lockout levels
`timescale 1ns/1ps
module cmps_sync #(
  parameter int unsigned W = 1
) (
  // Clock and control
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cmps_sync_s;

  cmps_sync_s st;
  cmps_sync_s next_st;

  // ==========================================================================
  // Only the second stage is visible outside
  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule // cmps_sync

/* File: hw/cmps_pwm.sv */
// Current-mode PWM switching-cycle controller with soft start and jitter
// Operation
// - Oscillator sets latch; any enabled comparator trip clears.
// - Cleared latch turns gate off immediately.
// - 65 kHz, four percent jitter, 4 ms.
// - Jitter only after soft start completes.
// - On-phase ends at 0.75 of period.
// - Gate held off 156 ns after trigger.
// - Soft start begins on lockout release.
// - 32 soft-start steps, one per 600 us.
// - Soft start ends at 20 ms, limit released.
// - Duty ramps from zero to maximum.
// - Every restart attempt reruns soft start.
// - Gate low while supply under lockout.
// - Current-limit trip ends every cycle's pulse.
// - Sense trips blanked 220 ns after turn-on.
// - Burst flag enables reduced current-limit trip.
// - Lockout off clears the soft-start counter.
`timescale 1ns/1ps
module cmps_pwm #(
  parameter int unsigned SS_STEP_CYC    = cmps_pkg::SS_STEP_US * cmps_pkg::CYC_PER_US_X,
  parameter int unsigned SS_TOTAL_CYC   = cmps_pkg::SS_TOTAL_MS * cmps_pkg::CYC_PER_MS,
  parameter int unsigned JIT_PERIOD_CYC = cmps_pkg::JIT_PERIOD_MS * cmps_pkg::CYC_PER_MS
) (
  // Clock and control
  input  wire logic                              sys_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              clk_en,
  // Comparator trips, asynchronous levels
  input  wire logic                              feedback_pwm_comparator,
  input  wire logic                              soft_start_comparator,
  input  wire logic                              current_limit_comparator,
  input  wire logic                              burst_current_limit_comparator,
  // Supply lockout, high while supply is above threshold
  input  wire logic                              supply_ok,
  // Control unit, same clock
  input  wire logic                              burst_flag,
  input  wire logic                              restart_attempt,
  // Gate and oscillator
  output logic                                   gate_drive,
  output logic                                   oscillator_phase,
  output logic                                   ramp_reset_switch,
  // Soft start
  output logic [cmps_pkg::SS_STEP_W-1:0]         soft_start_level,
  output logic                                   soft_start_done
);

  localparam int unsigned JIT_STEP_CYC = JIT_PERIOD_CYC / (4 * cmps_pkg::JIT_DEV);
  localparam logic [cmps_pkg::PER_W-1:0] PER_NOM_V  = cmps_pkg::PER_W'(cmps_pkg::PER_NOM);
  localparam logic [cmps_pkg::OFS_W-1:0] JIT_MAX    = cmps_pkg::OFS_W'(cmps_pkg::JIT_DEV);
  localparam logic [cmps_pkg::OFS_W-1:0] JIT_MIN    = cmps_pkg::OFS_W'(-cmps_pkg::JIT_DEV);
  localparam logic [cmps_pkg::DLY_W-1:0] MINOFF_V   = cmps_pkg::DLY_W'(cmps_pkg::MINOFF_CYC);
  localparam logic [cmps_pkg::DLY_W-1:0] LEB_V      = cmps_pkg::DLY_W'(cmps_pkg::LEB_CYC);
  localparam logic [cmps_pkg::TMR_W-1:0] JIT_LAST   = cmps_pkg::TMR_W'(JIT_STEP_CYC - 1);
  localparam logic [cmps_pkg::TMR_W-1:0] SS_LAST    = cmps_pkg::TMR_W'(SS_TOTAL_CYC - 1);
  localparam logic [cmps_pkg::TMR_W-1:0] STEP_LAST  = cmps_pkg::TMR_W'(SS_STEP_CYC - 1);
  localparam logic [cmps_pkg::SS_STEP_W-1:0] STEP_TOP =
    cmps_pkg::SS_STEP_W'(cmps_pkg::SS_STEPS - 1);

  typedef struct packed {
    logic                           uvlo_ok;
    logic [cmps_pkg::PER_W-1:0]     phase_cnt;
    logic [cmps_pkg::PER_W-1:0]     period;
    logic [cmps_pkg::OFS_W-1:0]     jit_ofs;
    logic                           jit_up;
    logic [cmps_pkg::TMR_W-1:0]     jit_tmr;
    logic                           osc_on;
    logic                           ramp_closed;
    logic                           latch;
    logic [cmps_pkg::DLY_W-1:0]     dly;
    logic [cmps_pkg::DLY_W-1:0]     leb;
    logic                           gate;
    logic [cmps_pkg::TMR_W-1:0]     ss_tmr;
    logic [cmps_pkg::TMR_W-1:0]     step_tmr;
    logic [cmps_pkg::SS_STEP_W-1:0] ss_step;
    logic                           ss_done;
  } cmps_state_s;

  cmps_state_s                  st;
  cmps_state_s                  next_st;
  logic [cmps_pkg::SYNC_W-1:0]  trip_raw;
  logic [cmps_pkg::SYNC_W-1:0]  trip_s;
  logic                         osc_pulse;
  logic                         blank;
  logic                         trip_any;
  logic                         raw_trip;
  logic [cmps_pkg::PER_W+1:0]   on_prod;
  logic [cmps_pkg::PER_W-1:0]   max_on;

  // ==========================================================================
  // Input synchronisers
  always_comb begin
    trip_raw                    = '0;
    trip_raw[cmps_pkg::LN_FB]   = feedback_pwm_comparator;
    trip_raw[cmps_pkg::LN_SS]   = soft_start_comparator;
    trip_raw[cmps_pkg::LN_CL]   = current_limit_comparator;
    trip_raw[cmps_pkg::LN_BCL]  = burst_current_limit_comparator;
    trip_raw[cmps_pkg::LN_UVLO] = supply_ok;
  end

  cmps_sync #(
    .W        (cmps_pkg::SYNC_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (trip_raw),
    .sync_out (trip_s)
  );

  // ==========================================================================
  // Cycle logic
  always_comb begin
    next_st   = st;
    osc_pulse = st.uvlo_ok && (st.phase_cnt == '0);
    on_prod   = {2'b00, st.period} * (cmps_pkg::PER_W + 2)'(cmps_pkg::DMAX_NUM);
    max_on    = cmps_pkg::PER_W'(on_prod / (cmps_pkg::PER_W + 2)'(cmps_pkg::DMAX_DEN));
    blank     = (st.leb != '0);
    // Sense-derived trips share one blanked path; burst limit only in burst
    trip_any  = !blank && (trip_s[cmps_pkg::LN_FB] || trip_s[cmps_pkg::LN_CL]
                || (burst_flag && trip_s[cmps_pkg::LN_BCL])
                || (!st.ss_done && trip_s[cmps_pkg::LN_SS]));

    next_st.uvlo_ok = trip_s[cmps_pkg::LN_UVLO];

    // Oscillator; the jittered period loads at wrap, and is forced to nominal in any cycle under lockout, restart or soft start
    if (!st.uvlo_ok) begin
      next_st.phase_cnt = '0;
      next_st.period    = PER_NOM_V;
    end else if (st.phase_cnt >= st.period - 1'b1) begin
      next_st.phase_cnt = '0;
      next_st.period    = PER_NOM_V + {{(cmps_pkg::PER_W - cmps_pkg::OFS_W){st.jit_ofs[
                          cmps_pkg::OFS_W-1]}}, st.jit_ofs};
    end else begin
      next_st.phase_cnt = st.phase_cnt + 1'b1;
    end
    next_st.osc_on      = next_st.uvlo_ok && (next_st.phase_cnt < max_on);
    next_st.ramp_closed = !next_st.osc_on;

    // Triangular jitter sweep, frozen at nominal during soft start
    // A restart or lockout drop freezes it at once, not one cycle late
    if (!st.ss_done || !st.uvlo_ok || restart_attempt) begin
      next_st.period  = PER_NOM_V;
      next_st.jit_ofs = '0;
      next_st.jit_up  = 1'b1;
      next_st.jit_tmr = '0;
    end else if (st.jit_tmr >= JIT_LAST) begin
      next_st.jit_tmr = '0;
      if (st.jit_up) begin
        if (st.jit_ofs == JIT_MAX) begin
          next_st.jit_up  = 1'b0;
          next_st.jit_ofs = st.jit_ofs - 1'b1;
        end else begin
          next_st.jit_ofs = st.jit_ofs + 1'b1;
        end
      end else begin
        if (st.jit_ofs == JIT_MIN) begin
          next_st.jit_up  = 1'b1;
          next_st.jit_ofs = st.jit_ofs + 1'b1;
        end else begin
          next_st.jit_ofs = st.jit_ofs - 1'b1;
        end
      end
    end else begin
      next_st.jit_tmr = st.jit_tmr + 1'b1;
    end

    // PWM latch: oscillator pulse sets, duty limit or trip clears
    if (!st.uvlo_ok) begin
      next_st.latch = 1'b0;
    end else if (osc_pulse) begin
      next_st.latch = 1'b1;
    end else if (!st.osc_on || trip_any) begin
      next_st.latch = 1'b0;
    end

    // Minimum off delay lets duty fall continuously to zero
    if (osc_pulse) begin
      next_st.dly = MINOFF_V;
    end else if (st.dly != '0) begin
      next_st.dly = st.dly - 1'b1;
    end

    next_st.gate = next_st.latch && (next_st.dly == '0) && st.uvlo_ok
                   && next_st.osc_on;

    if (next_st.gate && !st.gate) begin
      next_st.leb = LEB_V;
    end else if (st.leb != '0) begin
      next_st.leb = st.leb - 1'b1;
    end

    // Soft start; a lockout drop or restart always begins again from zero
    if (!st.uvlo_ok || restart_attempt) begin
      next_st.ss_tmr   = '0;
      next_st.step_tmr = '0;
      next_st.ss_step  = '0;
      next_st.ss_done  = 1'b0;
    end else if (!st.ss_done) begin
      next_st.ss_tmr = st.ss_tmr + 1'b1;
      if (st.ss_tmr >= SS_LAST) begin
        next_st.ss_done = 1'b1;
      end
      if (st.step_tmr >= STEP_LAST) begin
        next_st.step_tmr = '0;
        if (st.ss_step != STEP_TOP) begin
          next_st.ss_step = st.ss_step + 1'b1;
        end
      end else begin
        next_st.step_tmr = st.step_tmr + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st        <= '0;
      // Period idles at nominal so the jitter band holds out of reset
      st.period <= PER_NOM_V;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs; the unblanked raw trip path cuts the gate without a clock edge
  always_comb begin
    raw_trip = (st.leb == '0) && (feedback_pwm_comparator || current_limit_comparator
               || (burst_flag && burst_current_limit_comparator)
               || (!st.ss_done && soft_start_comparator));
  end

  assign gate_drive        = st.gate && !raw_trip;
  assign oscillator_phase  = st.osc_on;
  assign ramp_reset_switch = st.ramp_closed;
  assign soft_start_level  = st.ss_step;
  assign soft_start_done   = st.ss_done;

  // ==========================================================================
  // Assertions
  // Checks pause while disabled, since a frozen block holds every value
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  // Gate path
  a_gate_uvlo_low: assert property (!st.uvlo_ok |-> !gate_drive)
    else $error("gate driven while supply under lockout");
  a_latch_gate_off: assert property (!st.latch |-> !st.gate && !gate_drive)
    else $error("gate on with latch cleared");
  a_raw_cut: assert property (
    st.leb == '0 && current_limit_comparator |-> !gate_drive)
    else $error("unblanked current trip left gate on");
  a_duty_limit: assert property (!st.osc_on |-> !st.gate)
    else $error("gate on beyond maximum duty");
  a_min_off_hold: assert property (osc_pulse |=> !st.gate [*4])
    else $error("gate on inside minimum off delay");
  a_blank_hold: assert property (
    $rose(st.gate) |-> (st.gate || !st.uvlo_ok || !st.osc_on) [*6])
    else $error("gate ended inside blanking window");

  // Latch reset sources
  a_cl_trip_end: assert property (
    st.latch && !osc_pulse && !blank && trip_s[cmps_pkg::LN_CL] |=> !st.latch)
    else $error("current-limit trip did not clear latch");
  a_burst_trip: assert property (
    st.latch && !osc_pulse && !blank && burst_flag && trip_s[cmps_pkg::LN_BCL] |=> !st.latch)
    else $error("burst limit trip did not clear latch");
  a_burst_masked: assert property (
    st.latch && st.osc_on && !osc_pulse && !burst_flag && !trip_s[cmps_pkg::LN_FB]
    && !trip_s[cmps_pkg::LN_CL] && (st.ss_done || !trip_s[cmps_pkg::LN_SS]) |=> st.latch)
    else $error("burst limit trip honoured without flag");

  // Oscillator jitter
  a_jitter_frozen: assert property (
    !st.ss_done |-> st.jit_ofs == '0 && st.period == PER_NOM_V)
    else $error("jitter active during soft start");
  a_jitter_bound: assert property (
    st.period >= PER_NOM_V - cmps_pkg::PER_W'(cmps_pkg::JIT_DEV)
    && st.period <= PER_NOM_V + cmps_pkg::PER_W'(cmps_pkg::JIT_DEV))
    else $error("period outside jitter band");
  a_jit_step: assert property (
    st.ss_done && $changed(st.jit_ofs) |-> st.jit_ofs == $past(st.jit_ofs) + 1'b1
    || st.jit_ofs == $past(st.jit_ofs) - 1'b1)
    else $error("jitter offset jumped");

  // Soft start
  a_step_by_one: assert property (
    $changed(st.ss_step) |-> st.ss_step == '0 || st.ss_step == $past(st.ss_step) + 1'b1)
    else $error("soft-start level skipped a step");
  a_ss_start: assert property (
    st.uvlo_ok && !st.ss_done && !restart_attempt |=> st.ss_tmr == $past(st.ss_tmr) + 1'b1)
    else $error("soft start not counting after lockout release");
  a_ss_clear: assert property ($fell(st.uvlo_ok) |=> st.ss_step == '0 && !st.ss_done)
    else $error("soft start not cleared at lockout");
  a_restart_rerun: assert property (restart_attempt |=> !st.ss_done && st.ss_tmr == '0)
    else $error("restart did not rerun soft start");
  a_ss_release: assert property (
    st.ss_done && st.uvlo_ok && !restart_attempt |=> st.ss_done)
    else $error("soft start done dropped without cause");

  // Main scenarios
  c_gate_pulse: cover property ($rose(st.gate) ##[1:300] $fell(st.gate));
  c_ss_done: cover property ($rose(st.ss_done));
  c_burst_end: cover property (burst_flag && st.latch ##1 !st.latch && st.osc_on);
  c_jitter_low: cover property (st.jit_ofs == JIT_MIN);
  c_ss_rerun: cover property ($fell(st.ss_done));

endmodule // cmps_pwm

/* File: dv/cmps_sense_model.sv */
// Behavioural switch and sense comparators facing the gate output
`timescale 1ns/1ps
module cmps_sense_model (
  // Clock
  input  wire logic       sys_clk,
  // Gate and ramp switch from the controller
  input  wire logic       gate_drive,
  input  wire logic       ramp_reset_switch,
  // Trip set-up
  input  wire logic [1:0] lane,
  input  wire logic [9:0] trip_at,
  input  wire logic       spike,
  // Comparator levels
  output logic            feedback_pwm_comparator,
  output logic            soft_start_comparator,
  output logic            current_limit_comparator,
  output logic            burst_current_limit_comparator
);
  // ==========================================================================
  // Sense ramp
  // Trip is registered so that the combinational gate-off path sees no loop
  // The ramp keeps a trip standing until the ramp switch closes again
  logic [9:0] on_cnt;
  logic       trip;

  initial begin
    on_cnt = 10'h000;
    trip   = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (ramp_reset_switch !== 1'b0) begin
      on_cnt <= 10'h000;
      trip   <= 1'b0;
    end else if (gate_drive === 1'b1) begin
      on_cnt <= on_cnt + 10'h001;
      if (on_cnt == trip_at) trip <= 1'b1;
      // Spike mode models the turn-on spike, short enough to stay blanked
      if (spike && on_cnt == 10'h000) trip <= 1'b1;
      if (spike && on_cnt == 10'h001) trip <= 1'b0;
    end
  end

  assign feedback_pwm_comparator        = trip && lane == 2'h0;
  assign soft_start_comparator          = trip && lane == 2'h1;
  assign current_limit_comparator       = trip && lane == 2'h2;
  assign burst_current_limit_comparator = trip && lane == 2'h3;
endmodule // cmps_sense_model

/* File: dv/cmps_pwm_tb_top.sv */
// Self-checking bench for the switching-cycle controller
`timescale 1ns/1ps
module cmps_pwm_tb_top;
  // ==========================================================================
  // Signals
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       supply_ok = 1'b0;
  logic       burst_flag = 1'b0;
  logic       restart_attempt = 1'b0;
  logic [1:0] lane = 2'h2;
  logic [9:0] trip_at = 10'h3FF;
  logic       spike = 1'b0;
  logic       fb_c, ss_c, cl_c, bcl_c;
  logic       gate_drive, oscillator_phase, ramp_reset_switch, soft_start_done;
  logic [cmps_pkg::SS_STEP_W-1:0] soft_start_level;
  int         err_total = 0;
  int         checks_done = 0;

  always #25 sys_clk = ~sys_clk;

  cmps_pwm #(.SS_STEP_CYC(20), .SS_TOTAL_CYC(700), .JIT_PERIOD_CYC(480)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .feedback_pwm_comparator(fb_c), .soft_start_comparator(ss_c),
    .current_limit_comparator(cl_c), .burst_current_limit_comparator(bcl_c),
    .supply_ok(supply_ok), .burst_flag(burst_flag), .restart_attempt(restart_attempt),
    .gate_drive(gate_drive), .oscillator_phase(oscillator_phase),
    .ramp_reset_switch(ramp_reset_switch), .soft_start_level(soft_start_level),
    .soft_start_done(soft_start_done));

  cmps_sense_model i_sense (
    .sys_clk(sys_clk), .gate_drive(gate_drive), .ramp_reset_switch(ramp_reset_switch),
    .lane(lane), .trip_at(trip_at),
    .spike(spike), .feedback_pwm_comparator(fb_c), .soft_start_comparator(ss_c),
    .current_limit_comparator(cl_c), .burst_current_limit_comparator(bcl_c));

  // ==========================================================================
  // Helpers
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // Gate high time and rise-to-rise period, in clock cycles
  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    while (gate_drive !== 1'b1 && n < 1000) begin @(negedge sys_clk); n++; end
    hi = 0;
    while (gate_drive === 1'b1 && hi < 1000) begin @(negedge sys_clk); hi++; end
    per = hi;
    while (gate_drive !== 1'b1 && per < 1000) begin @(negedge sys_clk); per++; end
    if (n >= 1000 || per >= 1000) begin
      chk(1'b0, "gate wait timed out");
      finish_test();
    end
  endtask

  task automatic set_trip(input logic [1:0] l, input int at, input bit sp);
    @(posedge sys_clk);
    lane    <= l;
    trip_at <= 10'(at);
    spike   <= sp;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_lockout();
    int hits;
    hits = 0;
    chk(gate_drive === 1'b0 && soft_start_level === 5'h00, "outputs not idle");
    chk(soft_start_done === 1'b0, "done set in reset");
    repeat (400) begin @(negedge sys_clk); if (gate_drive !== 1'b0) hits++; end
    chk(hits == 0, "gate high under lockout");
    chk(ramp_reset_switch === 1'b1 && oscillator_phase === 1'b0, "ramp not held");
  endtask

  task automatic s_max_duty();
    int hi, per;
    measure(hi, per);
    repeat (2) begin
      measure(hi, per);
      chk(oscillator_phase === 1'b1 && ramp_reset_switch === 1'b0, "ramp not released");
      chk(hi >= 224 && hi <= 227, "on-phase not three quarters");
      chk(per == 307, "period not nominal");
      chk(per - hi >= 4, "off time too short");
    end
  endtask

  task automatic s_trips();
    int hi, per;
    set_trip(2'h2, 40, 1'b0);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 40 && hi <= 43, "current limit did not end pulse");
    set_trip(2'h0, 60, 1'b0);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 60 && hi <= 63, "feedback trip did not end pulse");
    set_trip(2'h1, 30, 1'b0);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 30 && hi <= 33, "soft-start trip did not end pulse");
    set_trip(2'h2, 1000, 1'b1);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 200, "turn-on spike not blanked");
    set_trip(2'h3, 20, 1'b0);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 200, "burst trip honoured without flag");
    @(posedge sys_clk);
    burst_flag <= 1'b1;
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 20 && hi <= 23, "burst trip ignored with flag");
    @(posedge sys_clk);
    burst_flag <= 1'b0;
    set_trip(2'h2, 1000, 1'b0);
  endtask

  task automatic s_soft_start();
    int n, t1;
    logic [4:0] lv;
    @(posedge sys_clk);
    restart_attempt <= 1'b0;
    n  = 0;
    t1 = 0;
    lv = 5'h00;
    while (soft_start_done !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
      if (soft_start_level !== lv) begin
        chk(soft_start_level === lv + 5'h01, "level skipped a step");
        if (lv != 5'h00) chk(n - t1 == 20, "step spacing wrong");
        lv = soft_start_level;
        t1 = n;
      end
    end
    if (n >= 2000) begin
      chk(1'b0, "soft start wait timed out");
      finish_test();
    end
    chk(n >= 698 && n <= 703, "soft start length wrong");
    chk(soft_start_level === 5'h1F, "level not at last step");
  endtask

  task automatic s_jitter();
    int hi, per, odd;
    odd = 0;
    // First pulse may be cut short, as the wait can start partway into it
    measure(hi, per);
    repeat (8) begin
      measure(hi, per);
      chk(per >= 295 && per <= 319, "jittered period out of range");
      if (per != 307) odd++;
    end
    chk(odd > 0, "no jitter after soft start");
    set_trip(2'h1, 30, 1'b0);
    measure(hi, per);
    measure(hi, per);
    chk(hi >= 200, "soft-start trip honoured after done");
    set_trip(2'h2, 1000, 1'b0);
  endtask

  task automatic s_restart();
    @(posedge sys_clk);
    restart_attempt <= 1'b1;
    @(posedge sys_clk);
    restart_attempt <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(soft_start_level === 5'h00 && soft_start_done === 1'b0, "restart kept level");
    repeat (100) @(negedge sys_clk);
    chk(soft_start_level !== 5'h00, "soft start not rerun");
    @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(soft_start_level === 5'h00, "lockout kept level");
    chk(gate_drive === 1'b0, "gate high after lockout");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    s_lockout();
    @(posedge sys_clk);
    supply_ok       <= 1'b1;
    restart_attempt <= 1'b1;
    s_max_duty();
    s_trips();
    s_soft_start();
    s_jitter();
    s_restart();
    finish_test();
  end
endmodule // cmps_pwm_tb_top
